//--- rtl/flag_ops_pkg.sv
// constants, opcodes, register map and carrier types of the flag-op unit
// assumes one core clock and a retire-ordered instruction stream
package flag_ops_pkg;

    // ------------------------------------------------------------
    // opcodes handled here
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_DIR = 8'hfd;
    localparam logic [7:0] OP_SET_IE = 8'hfb;
    localparam logic [7:0] OP_CLEAR_IE = 8'hfa;
    localparam logic [7:0] OP_TRAP_CALL = 8'hcd;
    localparam logic [7:0] OP_TRAP_RETURN = 8'hcf;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int DIR_BIT = 10;
    localparam int IF_BIT = 9;
    localparam logic [15:0] FLAGS_WRITABLE_MASK = 16'h0fd5;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // register map, word indexes taken from the address bits above bit 1
    // ------------------------------------------------------------
    localparam logic [1:0] REG_IDX_FLAGS = 2'h0;
    localparam logic [1:0] REG_IDX_STATUS = 2'h1;
    localparam int STATUS_SHADOW_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int EXEC_CLOCKS = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC1 = 3'h2,
        ST_EXEC2 = 3'h4
    } exec_state_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic iteration_prefix;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } instr_req_type;

    typedef struct packed {
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } index_pair_type;

endpackage

//--- rtl/string_index_step.sv
// one string index register step: up or down by the element size
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module string_index_step #(
    parameter int INDEX_W = 16
) (
    // operand
    input wire logic [INDEX_W-1:0] index_in,
    input wire logic direction_flag,
    input wire logic word_element,
    input wire logic step_enable,
    // result
    output logic [INDEX_W-1:0] index_out
);

    logic [INDEX_W-1:0] delta;

    always_comb begin
        delta = word_element ? INDEX_W'(2) : INDEX_W'(1);
        if (!step_enable) begin
            index_out = index_in;
        end else if (direction_flag) begin
            index_out = INDEX_W'(index_in - delta);
        end else begin
            index_out = INDEX_W'(index_in + delta);
        end
    end

endmodule

//--- rtl/direction_and_irq_enable_flag_ops.sv
// execution of direction / interrupt-enable flag instructions, string
// index stepping, and interrupt acceptance at instruction boundaries
// assumes the fetch side presents one decoded instruction at a time
//
// Behaviour
// - opcode fd writes 1 into the direction flag in two clocks.
// - with the direction flag at 1 every string op decrements its indexes.
// - set-direction changes only bit 10 of the status word.
// - opcode fb sets the interrupt enable at bit 9 in two clocks only.
// - after set-interrupt-enable no maskable entry until the next retires.
// - set then clear of the enable flag lets no maskable interrupt in.
// - nonmaskable interrupts and software traps ignore the enable flag.
// - a software trap call clears the interrupt enable flag.
// - trap return restores the enable flag from the saved status word.
// - string instructions step their indexes, prefix or not.
// - indexes step up at flag 0, down at 1, by 1 for bytes, 2 for words.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module direction_and_irq_enable_flag_ops #(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction stream
    input wire logic instr_valid,
    input wire flag_ops_pkg::instr_req_type instr_in,
    output logic instr_ready,
    output logic instr_done,
    output flag_ops_pkg::index_pair_type index_out,
    // interrupt side
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic [15:0] saved_flags,
    output logic take_maskable,
    output logic take_nmi,
    output logic trap_taken,
    output logic [15:0] flags_out,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        flag_ops_pkg::exec_state_type state;
        flag_ops_pkg::instr_req_type req;
        flag_ops_pkg::index_pair_type index;
        logic [15:0] flags;
        logic ie_shadow;
        logic done;
        logic take_maskable;
        logic take_nmi;
        logic trap_taken;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } unit_state_type;

    unit_state_type state_reg;
    unit_state_type state_next;
    logic [15:0] stepped [2];
    logic step_use [2];
    logic [15:0] step_base [2];
    logic [15:0] wr_merged;
    logic wr_fire;
    logic rd_fire;
    logic op_string;
    logic is_word;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // string decode
    // ------------------------------------------------------------
    function automatic logic string_op(input logic [7:0] op);
        string_op = (op[7:4] == 4'ha && op[3:0] >= 4'h4 && op[3:0] != 4'h8
            && op[3:0] != 4'h9) || (op[7:2] == 6'h1b);
    endfunction
    function automatic logic uses_source(input logic [7:0] op);
        uses_source = string_op(op) && (op[7:1] == 7'h52 || op[7:1] == 7'h53
            || op[7:1] == 7'h56 || op[7:1] == 7'h37);
    endfunction
    function automatic logic uses_dest(input logic [7:0] op);
        uses_dest = string_op(op) && (op[7:1] == 7'h52 || op[7:1] == 7'h53
            || op[7:1] == 7'h55 || op[7:1] == 7'h57 || op[7:1] == 7'h36);
    endfunction
    assign op_string = string_op(state_reg.req.opcode);
    assign is_word = state_reg.req.opcode[0];
    assign step_base[0] = state_reg.req.source_index;
    assign step_base[1] = state_reg.req.destination_index;
    // the prefix does not gate the step: a repeat count lives elsewhere
    assign step_use[0] = uses_source(state_reg.req.opcode);
    assign step_use[1] = uses_dest(state_reg.req.opcode);

    // ------------------------------------------------------------
    // index steppers, source then destination
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : gen_step
        string_index_step #(
            .INDEX_W(16)
        ) u_step (
            .index_in(step_base[g]),
            .direction_flag(state_reg.flags[flag_ops_pkg::DIR_BIT]),
            .word_element(is_word),
            .step_enable(step_use[g]),
            .index_out(stepped[g])
        );
    end

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    assign instr_ready = (state_reg.state == flag_ops_pkg::ST_IDLE);
    assign awready = !state_reg.aw_have && !state_reg.bvalid;
    assign wready = !state_reg.w_have && !state_reg.bvalid;
    assign arready = !state_reg.rvalid;
    assign wr_fire = state_reg.aw_have && state_reg.w_have
        && !state_reg.bvalid;
    assign rd_fire = arvalid && arready;

    always_comb begin
        wr_merged = state_reg.flags;
        if (state_reg.w_strb[0]) begin
            wr_merged[7:0] = state_reg.w_data[7:0];
        end
        if (state_reg.w_strb[1]) begin
            wr_merged[15:8] = state_reg.w_data[15:8];
        end
        wr_merged = wr_merged & flag_ops_pkg::FLAGS_WRITABLE_MASK;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.take_maskable = 1'b0;
        state_next.take_nmi = 1'b0;
        state_next.trap_taken = 1'b0;

        // bus write: address and data may come in either order
        if (awvalid && awready) begin
            state_next.aw_have = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            state_next.w_have = 1'b1;
            state_next.w_data = wdata;
            state_next.w_strb = wstrb;
        end
        if (wr_fire) begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = flag_ops_pkg::RESP_OKAY;
            unique case (state_reg.aw_addr[ADDR_W-1:2])
                (ADDR_W-2)'(flag_ops_pkg::REG_IDX_FLAGS): begin
                    state_next.flags = wr_merged;
                end
                // status is read-only; a write is accepted and dropped
                (ADDR_W-2)'(flag_ops_pkg::REG_IDX_STATUS): begin
                end
                default: begin
                    state_next.bresp = flag_ops_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end

        // bus read
        if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = 32'h0;
            state_next.rresp = flag_ops_pkg::RESP_OKAY;
            unique case (araddr[ADDR_W-1:2])
                (ADDR_W-2)'(flag_ops_pkg::REG_IDX_FLAGS): begin
                    state_next.rdata = {16'h0, state_reg.flags};
                end
                (ADDR_W-2)'(flag_ops_pkg::REG_IDX_STATUS): begin
                    state_next.rdata[flag_ops_pkg::STATUS_SHADOW_BIT] =
                        state_reg.ie_shadow;
                    state_next.rdata[flag_ops_pkg::STATUS_BUSY_BIT] =
                        (state_reg.state != flag_ops_pkg::ST_IDLE);
                end
                default: begin
                    state_next.rresp = flag_ops_pkg::RESP_SLVERR;
                end
            endcase
        end

        // execution: the instruction's own flag change is applied after a
        // same-cycle bus write, so hardware wins on the bit it touches
        unique case (state_reg.state)
            flag_ops_pkg::ST_IDLE: begin
                if (instr_valid) begin
                    state_next.req = instr_in;
                    state_next.state = flag_ops_pkg::ST_EXEC1;
                end
            end
            flag_ops_pkg::ST_EXEC1: begin
                state_next.state = flag_ops_pkg::ST_EXEC2;
            end
            flag_ops_pkg::ST_EXEC2: begin
                state_next.state = flag_ops_pkg::ST_IDLE;
                state_next.done = 1'b1;
                state_next.index.source_index = stepped[0];
                state_next.index.destination_index = stepped[1];
                unique case (state_reg.req.opcode)
                    flag_ops_pkg::OP_SET_DIR: begin
                        state_next.flags[flag_ops_pkg::DIR_BIT] = 1'b1;
                    end
                    flag_ops_pkg::OP_SET_IE: begin
                        state_next.flags[flag_ops_pkg::IF_BIT] = 1'b1;
                    end
                    flag_ops_pkg::OP_CLEAR_IE: begin
                        state_next.flags[flag_ops_pkg::IF_BIT] = 1'b0;
                    end
                    flag_ops_pkg::OP_TRAP_CALL: begin
                        state_next.flags[flag_ops_pkg::IF_BIT] = 1'b0;
                        state_next.trap_taken = 1'b1;
                    end
                    flag_ops_pkg::OP_TRAP_RETURN: begin
                        state_next.flags = saved_flags
                            & flag_ops_pkg::FLAGS_WRITABLE_MASK;
                    end
                    default: begin
                    end
                endcase
                // shadow from this retire holds off maskable entry here only
                state_next.ie_shadow =
                    (state_reg.req.opcode == flag_ops_pkg::OP_SET_IE);
                if (nmi_req) begin
                    state_next.take_nmi = 1'b1;
                end else if (irq_req && !state_next.ie_shadow
                    && state_next.flags[flag_ops_pkg::IF_BIT]
                    && state_reg.req.opcode
                        != flag_ops_pkg::OP_TRAP_CALL) begin
                    state_next.take_maskable = 1'b1;
                    state_next.flags[flag_ops_pkg::IF_BIT] = 1'b0;
                end
            end
            default: begin
                state_next.state = flag_ops_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.state <= flag_ops_pkg::ST_IDLE;
            state_reg.flags <= flag_ops_pkg::FLAGS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign instr_done = state_reg.done;
    assign index_out = state_reg.index;
    assign take_maskable = state_reg.take_maskable;
    assign take_nmi = state_reg.take_nmi;
    assign trap_taken = state_reg.trap_taken;
    assign flags_out = state_reg.flags;
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic exec_last;
    assign exec_last = (state_reg.state == flag_ops_pkg::ST_EXEC2);
    sequence accept_set_dir;
        instr_valid && instr_ready
            && instr_in.opcode == flag_ops_pkg::OP_SET_DIR;
    endsequence
    sequence two_clock_exec;
        (state_reg.state == flag_ops_pkg::ST_EXEC1) ##1 exec_last
            ##1 (instr_done && flags_out[flag_ops_pkg::DIR_BIT]);
    endsequence
    chk_set_dir_timing: assert property (
        accept_set_dir |=> two_clock_exec)
        else $error("set-direction did not finish in two clocks");
    chk_dir_only_bit: assert property (
        exec_last && state_reg.req.opcode == flag_ops_pkg::OP_SET_DIR
            && !wr_fire && !nmi_req && !irq_req
        |=> (flags_out ^ $past(flags_out)) == 16'h0400
            || flags_out == $past(flags_out))
        else $error("set-direction touched another flag");
    chk_ie_only_bit: assert property (
        exec_last && state_reg.req.opcode == flag_ops_pkg::OP_SET_IE
            && !wr_fire
        |=> flags_out[flag_ops_pkg::IF_BIT]
            && (flags_out & 16'hfdff) == ($past(flags_out) & 16'hfdff))
        else $error("set-interrupt-enable result wrong");
    chk_decrement_byte: assert property (
        exec_last && uses_dest(state_reg.req.opcode) && !is_word
            && state_reg.flags[flag_ops_pkg::DIR_BIT]
        |=> index_out.destination_index
            == 16'($past(state_reg.req.destination_index) - 16'h0001))
        else $error("destination index not decremented");
    chk_increment_word: assert property (
        exec_last && uses_source(state_reg.req.opcode) && is_word
            && !state_reg.flags[flag_ops_pkg::DIR_BIT]
        |=> index_out.source_index
            == 16'($past(state_reg.req.source_index) + 16'h0002))
        else $error("source index not advanced by two");
    chk_step_with_prefix: assert property (
        exec_last && op_string && state_reg.req.iteration_prefix
        |=> index_out != {$past(state_reg.req.source_index),
            $past(state_reg.req.destination_index)})
        else $error("string op did not step its index");
    chk_ie_delay: assert property (
        instr_done && state_reg.req.opcode == flag_ops_pkg::OP_SET_IE
        |-> !take_maskable && state_reg.ie_shadow)
        else $error("maskable interrupt taken right after enable");
    chk_shadow_clear: assert property (
        exec_last && state_reg.req.opcode != flag_ops_pkg::OP_SET_IE
        |=> !state_reg.ie_shadow ##1 !state_reg.ie_shadow)
        else $error("shadow bit outlived next instruction");
    chk_no_irq_clear: assert property (
        instr_done && state_reg.req.opcode == flag_ops_pkg::OP_CLEAR_IE
        |-> !take_maskable)
        else $error("interrupt taken between enable and clear");
    chk_nmi_ignores_ie: assert property (
        exec_last && nmi_req |=> take_nmi && instr_done)
        else $error("nonmaskable interrupt not taken");
    chk_trap_clears_ie: assert property (
        exec_last && state_reg.req.opcode == flag_ops_pkg::OP_TRAP_CALL
        |=> trap_taken && !flags_out[flag_ops_pkg::IF_BIT])
        else $error("trap call left interrupts enabled");
    chk_return_restores: assert property (
        exec_last && state_reg.req.opcode == flag_ops_pkg::OP_TRAP_RETURN
            && !nmi_req && !irq_req
        |=> flags_out[flag_ops_pkg::IF_BIT]
            == $past(saved_flags[flag_ops_pkg::IF_BIT]))
        else $error("trap return did not restore enable flag");

endmodule

//--- verif/direction_and_irq_enable_flag_ops_tb.sv
// self-checking bench of the flag-op unit, driven at its ports
// assumes the designer's package and top module are compiled first
`timescale 1ns/1ps
module direction_and_irq_enable_flag_ops_tb;
    // ------------------------------------------------------------
    // stimulus and wires
    // ------------------------------------------------------------
    logic clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
    logic irq_req = 1'b0, nmi_req = 1'b0;
    logic [15:0] saved_flags = 16'h0000;
    flag_ops_pkg::instr_req_type instr_in = '0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic instr_ready, instr_done, take_maskable, take_nmi, trap_taken;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] flags_out;
    flag_ops_pkg::index_pair_type index_out;
    int fail_count = 0, comparisons = 0, n;
    direction_and_irq_enable_flag_ops dut_u (.clk(clk), .reset_n(reset_n),
        .instr_valid(instr_valid), .instr_in(instr_in),
        .instr_ready(instr_ready), .instr_done(instr_done),
        .index_out(index_out), .irq_req(irq_req), .nmi_req(nmi_req),
        .saved_flags(saved_flags), .take_maskable(take_maskable),
        .take_nmi(take_nmi), .trap_taken(trap_taken), .flags_out(flags_out),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // n counts edges from the taking edge to the retire cycle
    task automatic run_op(input logic [7:0] op, input logic pre,
                          input logic [15:0] si, di);
        @(posedge clk);
        instr_in <= '{op, pre, si, di};
        instr_valid <= 1'b1;
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (instr_done !== 1'b1 && n < 20);
        check(instr_done, 1'b1, "retire pulse");
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no cycle limit here: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check(bresp, resp, "bresp");
        bready <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        check(rdata, d, "rdata");
        check(rresp, resp, "rresp");
        rready <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_set_dir;
        bus_wr(4'h0, 32'h0bd5, 4'h3, 2'h0);
        run_op(8'hfd, 1'b0, 16'h1234, 16'h5678);
        check(n, flag_ops_pkg::EXEC_CLOCKS, "set dir latency");
        check(flags_out, 16'h0fd5, "set dir flags");
        check(index_out, 32'h12345678, "pass index");
    endtask
    task automatic t_strings;
        logic [7:0] ops [8] = '{8'ha4, 8'ha5, 8'haa, 8'hab,
                                8'hac, 8'had, 8'h6c, 8'h6f};
        logic [7:0] op;
        logic [15:0] w, es, ed;
        for (int df = 0; df < 2; df++) begin
            bus_wr(4'h0, df ? 32'h0400 : 32'h0, 4'h3, 2'h0);
            for (int i = 0; i < 8; i++) begin
                op = ops[i];
                w = op[0] ? 16'h2 : 16'h1;
                es = 16'h0001;
                ed = 16'hffff;
                if (op inside {8'ha4, 8'ha5, 8'hac, 8'had, 8'h6f})
                    es = df ? es - w : es + w;
                if (op inside {8'ha4, 8'ha5, 8'haa, 8'hab, 8'h6c})
                    ed = df ? ed - w : ed + w;
                run_op(op, i[0], 16'h0001, 16'hffff);
                check(index_out, {es, ed}, "string index");
            end
        end
    endtask
    task automatic t_set_ie;
        bus_wr(4'h0, 32'h0, 4'h3, 2'h0);
        irq_req <= 1'b1;
        run_op(8'hfb, 1'b0, 16'h0, 16'h0);
        check(n, flag_ops_pkg::EXEC_CLOCKS, "set ie latency");
        check(flags_out, 16'h0200, "set ie flags");
        check(take_maskable, 1'b0, "irq held off");
        bus_rd(4'h4, 32'h1, 2'h0);
        // request still up: it must be taken right after the next one
        run_op(8'h90, 1'b0, 16'h0, 16'h0);
        check(take_maskable, 1'b1, "irq after next");
        check(flags_out, 16'h0000, "irq clears ie");
        bus_rd(4'h4, 32'h0, 2'h0);
        run_op(8'hfb, 1'b0, 16'h0, 16'h0);
        check(take_maskable, 1'b0, "enable window");
        run_op(8'hfa, 1'b0, 16'h0, 16'h0);
        check(take_maskable, 1'b0, "enable then clear");
        check(flags_out, 16'h0000, "clear flags");
        irq_req <= 1'b0;
    endtask
    task automatic t_traps;
        nmi_req <= 1'b1;
        run_op(8'h90, 1'b0, 16'h0, 16'h0);
        check(take_nmi, 1'b1, "nmi with ie clear");
        nmi_req <= 1'b0;
        bus_wr(4'h0, 32'h0201, 4'h3, 2'h0);
        run_op(8'hcd, 1'b0, 16'h0, 16'h0);
        check(trap_taken, 1'b1, "trap taken");
        check(flags_out, 16'h0001, "trap clears ie");
        saved_flags <= 16'hffff;
        run_op(8'hcf, 1'b0, 16'h0, 16'h0);
        check(flags_out, 16'h0fd5, "return restores");
        saved_flags <= 16'h0000;
        run_op(8'hcf, 1'b0, 16'h0, 16'h0);
        check(flags_out, 16'h0000, "return restores clear");
    endtask
    task automatic t_bus;
        check(flags_out, 16'h0000, "reset flags");
        check(index_out, 32'h0, "reset index");
        bus_rd(4'h0, 32'h0, 2'h0);
        bus_rd(4'h4, 32'h0, 2'h0);
        bus_wr(4'h0, 32'hffff, 4'h1, 2'h0);
        bus_rd(4'h0, 32'h00d5, 2'h0);
        bus_wr(4'h4, 32'hffff, 4'hf, 2'h0);
        bus_rd(4'h4, 32'h0, 2'h0);
        bus_wr(4'hc, 32'h1, 4'hf, 2'h2);
        bus_rd(4'h8, 32'h0, 2'h2);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_bus();
        t_set_dir();
        t_strings();
        t_set_ie();
        t_traps();
        report_and_stop();
    end
    initial begin
        // a generous multiple of the under two hundred cycles the tests need
        #(25 * 20000);
        fail_count++;
        report_and_stop();
    end
endmodule
